// ### design/rbs_pkg.sv
// Package for the reset and boot sequencer: register map, field layout,
// reset values and timing constants.
// Assumes a 40 MHz reference clock and a 32-bit classic Wishbone bus.
package rbs_pkg;

  localparam int unsigned CLK_HZ = 40_000_000;

  // Byte offsets of the register words.
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ    = 8'h08;
  localparam logic [7:0] OFS_MASK   = 8'h0C;
  localparam logic [7:0] OFS_ERR    = 8'h10;

  // Control register fields.
  localparam int unsigned CB_CORE_RST_N   = 0;
  localparam int unsigned CB_FE_CLK_EN    = 1;
  localparam int unsigned CB_MPLL_EN      = 2;
  localparam int unsigned CB_DIV_RST_N    = 3;
  localparam int unsigned CB_EXT_RST_N    = 4;
  localparam int unsigned CB_INIT_DONE    = 5;
  localparam int unsigned CB_LOW_POWER    = 6;
  localparam int unsigned CB_CPU_CLK_DIV  = 7;
  localparam int unsigned CB_ERR_PULSE    = 8;
  localparam int unsigned CB_MIRROR_OE    = 9;
  localparam int unsigned CB_SOFT_RESET   = 10;
  localparam int unsigned CTRL_W          = 11;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h000;

  // Event bits, shared by the interrupt and mask words.
  localparam int unsigned EV_PLL_LOCK  = 0;
  localparam int unsigned EV_WAKE      = 1;
  localparam int unsigned EV_SUPPLY    = 2;
  localparam int unsigned EV_WDOG      = 3;
  localparam int unsigned EV_W         = 4;

  // Status word fields; only the PLL lock bit matches an event bit.
  localparam int unsigned SB_PLL_LOCK  = 0;
  localparam int unsigned SB_BUSY      = 1;
  localparam int unsigned SB_POR_SEEN  = 2;
  localparam int unsigned SB_CAUSE_LO  = 3;
  localparam int unsigned CAUSE_W      = 2;

  localparam logic [CAUSE_W-1:0] CAUSE_POR    = 2'h0;
  localparam logic [CAUSE_W-1:0] CAUSE_SUPPLY = 2'h1;
  localparam logic [CAUSE_W-1:0] CAUSE_WDOG   = 2'h2;
  localparam logic [CAUSE_W-1:0] CAUSE_SOFT   = 2'h3;

  // Status pin rises within this time after reset release.
  localparam int unsigned BUSY_RISE_NS  = 500;
  localparam int unsigned BUSY_RISE_CYC = (BUSY_RISE_NS * (CLK_HZ / 1_000_000)) / 1000;
  // Width of the error pulse on the status pin.
  localparam int unsigned ERR_PULSE_NS  = 1000;
  localparam int unsigned ERR_PULSE_CYC = (ERR_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // Cycles the system reset is held after its cause goes away.
  localparam int unsigned SYS_HOLD_CYC  = 16;
  localparam int unsigned CNT_W         = 8;

endpackage : rbs_pkg

// ### design/rbs_sequencer.sv
// Reset and boot sequencer for a display controller: system reset
// collection, default pin states, clock and reset gating, init status pin.
// Assumes the embedded processor drives the Wishbone port and that pads
// resolve the output enables; a watchdog elsewhere supplies wdog_expired.
//
// Operation
// R1: Power-up starts master PLL, then system reset.
// R2: Any reset source restores normal mode, defaults.
// R3: General pins float during and after reset.
// R4: Master PLL resets only on power-up.
// R5: Only processor resets released after reset.
// R6: Processor clocks full rate after reset.
// R7: Front-end clocks disabled until software enables.
// R8: Mirror PLL off, clocks stopped, resets held.
// R9: Mirror outputs low, output enable floating.
// R10: External resets held until processor releases.
// R11: Processor boots from external program flash.
// R12: Mirror PLL enabled, divider held, then rates.
// R13: Divider release starts clocks, then external resets.
// R14: Wake request restores normal mode and clocks.
// R15: Status pin high shortly after reset release.
// R16: Host waits until busy status goes low.
// R17: Error shown as pulse, cause recorded.
// R18: Resets assert asynchronously, release synchronously.
//
// The Wishbone slave port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none

module rbs_sequencer #(
  parameter int unsigned GPIO_W   = 38,
  parameter int unsigned MIRROR_W = 16
) (
  input  wire logic                  ref_clk,
  input  wire logic                  nrst,
  input  wire logic                  supply_good_input,
  input  wire logic                  wdog_expired,
  input  wire logic                  wake_request,
  input  wire logic                  mirror_interface_pll_lock,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  output logic                       master_pll_rst,
  output logic                       normal_power,
  output logic                       cpu_rst_n,
  output logic                       cpu_clk_full,
  output logic                       boot_from_flash,
  output logic                       core_rst_n,
  output logic                       fe_clk_en,
  output logic                       mirror_interface_pll_en,
  output logic                       ddr_clock_generator_div_rst_n,
  output logic                       mirror_clk_en,
  output logic                       ext_rst_n,
  output logic      [GPIO_W-1:0]     gpio_oe,
  output logic      [MIRROR_W-1:0]   mirror_data_o,
  output logic      [MIRROR_W-1:0]   mirror_data_oe,
  output logic                       mirror_driver_output_enable_n,
  output logic                       mirror_driver_output_enable_n_oe,
  output logic                       init_status,
  output logic                       irq
);

  // Pin inputs pass two flip-flops before use.
  logic [3:0] sync1;
  logic [3:0] sync2;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      // The supply bit resets to good, so reset release cannot raise a false supply event.
      sync1 <= 4'h1;
      sync2 <= 4'h1;
    end else begin
      sync1 <= {mirror_interface_pll_lock, wake_request, wdog_expired, supply_good_input};
      sync2 <= sync1;
    end
  end
  wire logic supply_ok = sync2[0];
  wire logic wdog_s    = sync2[1];
  wire logic wake_s    = sync2[2];
  wire logic lock_s    = sync2[3];

  // Power-up reset: the only source that touches the master PLL.
  logic por_done;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) por_done <= 1'b0;
    else       por_done <= 1'b1;
  end
  assign master_pll_rst = !por_done; // see R4, R1

  // System reset collection and stretched hold.
  logic                        soft_reset;
  logic [rbs_pkg::CNT_W-1:0]   hold_cnt;
  logic                        sys_rst;
  logic [rbs_pkg::CAUSE_W-1:0] cause;
  wire logic sys_src = !supply_ok || wdog_s || soft_reset; // see R2
  wire logic [rbs_pkg::CAUSE_W-1:0] next_cause =
    !supply_ok ? rbs_pkg::CAUSE_SUPPLY : (wdog_s ? rbs_pkg::CAUSE_WDOG : rbs_pkg::CAUSE_SOFT);
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hold_cnt <= rbs_pkg::CNT_W'(rbs_pkg::SYS_HOLD_CYC);
      sys_rst  <= 1'b1;
      cause    <= rbs_pkg::CAUSE_POR;
    end else if (sys_src && por_done) begin
      hold_cnt <= rbs_pkg::CNT_W'(rbs_pkg::SYS_HOLD_CYC);
      sys_rst  <= 1'b1;
      cause    <= next_cause;
    end else if (hold_cnt != '0) begin
      hold_cnt <= hold_cnt - 1'b1;
    end else begin
      sys_rst  <= 1'b0; // see R18
    end
  end

  // Synchronous release of the processor reset, asynchronous assertion.
  logic [1:0] cpu_rst_sh;
  wire logic  sys_rst_n = nrst && !sys_rst;
  always_ff @(posedge ref_clk or negedge sys_rst_n) begin
    if (!sys_rst_n) cpu_rst_sh <= 2'h0; // see R18
    else            cpu_rst_sh <= {cpu_rst_sh[0], 1'b1};
  end
  assign cpu_rst_n       = cpu_rst_sh[1]; // see R5
  assign boot_from_flash = 1'b1;          // see R11

  // Control register, cleared by every system reset.
  logic [rbs_pkg::CTRL_W-1:0] ctrl;
  logic [rbs_pkg::EV_W-1:0]   irq_stat;
  logic [rbs_pkg::EV_W-1:0]   irq_mask;
  logic [7:0]                 err_code;

  wire logic wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic wb_wr  = wb_req && wb_we_i && wb_sel_i[0];
  wire logic wr_ctrl = wb_wr && (wb_adr_i == rbs_pkg::OFS_CTRL);
  wire logic wr_irq  = wb_wr && (wb_adr_i == rbs_pkg::OFS_IRQ);
  wire logic wr_mask = wb_wr && (wb_adr_i == rbs_pkg::OFS_MASK);
  wire logic wr_err  = wb_wr && (wb_adr_i == rbs_pkg::OFS_ERR);
  wire logic wr_ctrl_hi = wr_ctrl && wb_sel_i[1];

  // Mirror PLL may only be enabled with divider held; rates follow lock.
  wire logic [rbs_pkg::CTRL_W-1:0] ctrl_wdat = {wb_dat_i[rbs_pkg::CTRL_W-1:8] & {3{wr_ctrl_hi}} |
                                                ctrl[rbs_pkg::CTRL_W-1:8] & {3{!wr_ctrl_hi}},
                                                wb_dat_i[7:0]};
  always_ff @(posedge ref_clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      ctrl <= rbs_pkg::CTRL_RESET; // see R2, R5, R7, R8, R10
    end else begin
      if (wr_ctrl) ctrl <= ctrl_wdat;
      else         ctrl[rbs_pkg::CB_ERR_PULSE] <= 1'b0;
      if (wake_s) begin
        ctrl[rbs_pkg::CB_LOW_POWER]   <= 1'b0; // see R14
        ctrl[rbs_pkg::CB_CPU_CLK_DIV] <= 1'b0; // see R14
      end
    end
  end

  // Output stage: reset defaults are held by the register reset values.
  assign normal_power            = !ctrl[rbs_pkg::CB_LOW_POWER];         // see R2
  assign cpu_clk_full            = !ctrl[rbs_pkg::CB_CPU_CLK_DIV];       // see R6
  assign core_rst_n              = ctrl[rbs_pkg::CB_CORE_RST_N] && cpu_rst_n; // see R5
  assign fe_clk_en               = ctrl[rbs_pkg::CB_FE_CLK_EN];          // see R7
  assign mirror_interface_pll_en = ctrl[rbs_pkg::CB_MPLL_EN];            // see R8, R12
  // Divider release needs PLL lock so clocks never start on a wild PLL.
  assign ddr_clock_generator_div_rst_n = ctrl[rbs_pkg::CB_DIV_RST_N] && ctrl[rbs_pkg::CB_MPLL_EN] && lock_s; // see R12
  assign mirror_clk_en           = ddr_clock_generator_div_rst_n;        // see R13
  // External resets wait for the mirror clocks to run.
  assign ext_rst_n               = ctrl[rbs_pkg::CB_EXT_RST_N] && ddr_clock_generator_div_rst_n; // see R10, R13
  assign gpio_oe                 = '0; // see R3
  assign mirror_data_o           = '0; // see R9
  assign mirror_data_oe          = {MIRROR_W{cpu_rst_n}}; // see R9
  assign mirror_driver_output_enable_n    = !ctrl[rbs_pkg::CB_MIRROR_OE];
  assign mirror_driver_output_enable_n_oe = ctrl[rbs_pkg::CB_MIRROR_OE]; // see R9

  // Soft reset request is a single-cycle strobe from the register.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) soft_reset <= 1'b0;
    else       soft_reset <= wr_ctrl_hi && wb_dat_i[rbs_pkg::CB_SOFT_RESET];
  end

  // Init status: busy a few cycles after release, then error pulses.
  logic [rbs_pkg::CNT_W-1:0] busy_cnt;
  logic [rbs_pkg::CNT_W-1:0] pulse_cnt;
  logic                      busy;
  always_ff @(posedge ref_clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      busy_cnt  <= '0;
      busy      <= 1'b0;
      pulse_cnt <= '0;
    end else begin
      if (busy_cnt != rbs_pkg::CNT_W'(rbs_pkg::BUSY_RISE_CYC) && !ctrl[rbs_pkg::CB_INIT_DONE]) begin
        busy_cnt <= busy_cnt + 1'b1;
        busy     <= (busy_cnt + 1'b1) == rbs_pkg::CNT_W'(rbs_pkg::BUSY_RISE_CYC); // see R15
      end else if (ctrl[rbs_pkg::CB_INIT_DONE]) begin
        busy     <= 1'b0; // see R16
      end
      if (ctrl[rbs_pkg::CB_ERR_PULSE] && ctrl[rbs_pkg::CB_INIT_DONE]) begin
        pulse_cnt <= rbs_pkg::CNT_W'(rbs_pkg::ERR_PULSE_CYC); // see R17
      end else if (pulse_cnt != '0) begin
        pulse_cnt <= pulse_cnt - 1'b1;
      end
    end
  end
  assign init_status = busy || (pulse_cnt != '0); // see R15, R17

  // Sticky events: set wins over a write-one clear.
  logic [rbs_pkg::EV_W-1:0] lock_d;
  wire logic [rbs_pkg::EV_W-1:0] ev = {1'b0, 1'b0, wake_s && !lock_d[1], lock_s && !lock_d[0]};
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lock_d   <= '0;
      irq_stat <= '0;
      irq_mask <= '0;
      err_code <= '0;
    end else begin
      lock_d   <= {2'h0, wake_s, lock_s};
      irq_stat <= (irq_stat & ~(wb_dat_i[rbs_pkg::EV_W-1:0] & {rbs_pkg::EV_W{wr_irq}})) | ev
                  | {sys_rst && cause == rbs_pkg::CAUSE_WDOG, sys_rst && cause == rbs_pkg::CAUSE_SUPPLY, 2'h0};
      if (wr_mask) irq_mask <= wb_dat_i[rbs_pkg::EV_W-1:0];
      if (wr_err)  err_code <= wb_dat_i[7:0]; // see R17
    end
  end
  assign irq = |(irq_stat & irq_mask);

  // Wishbone read path, one wait state; unmapped reads return zero.
  wire logic [31:0] status_word = {27'h0, cause, por_done, busy, lock_s};
  wire logic [31:0] rd_mux =
    (wb_adr_i == rbs_pkg::OFS_CTRL)   ? {21'h0, ctrl} :
    (wb_adr_i == rbs_pkg::OFS_STATUS) ? status_word :
    (wb_adr_i == rbs_pkg::OFS_IRQ)    ? {28'h0, irq_stat} :
    (wb_adr_i == rbs_pkg::OFS_MASK)   ? {28'h0, irq_mask} :
    (wb_adr_i == rbs_pkg::OFS_ERR)    ? {24'h0, err_code} : 32'h0;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) wb_dat_o <= rd_mux;
    end
  end

  // Checks.
  // A system reset that follows power-up must leave the master PLL running.
  property p_pll_hold;
    @(posedge ref_clk) disable iff (!nrst)
    (por_done && !sys_rst_n) |-> !master_pll_rst;
  endproperty
  a_pll_hold: assert property (p_pll_hold) else $error("master PLL reset by system reset"); // see R4

  property p_fe_off;
    @(posedge ref_clk) disable iff (!nrst)
    $rose(cpu_rst_n) |-> !fe_clk_en && !mirror_interface_pll_en && !ext_rst_n;
  endproperty
  a_fe_off: assert property (p_fe_off) else $error("defaults lost"); // see R7

  property p_ext;
    @(posedge ref_clk) disable iff (!nrst)
    ext_rst_n |-> mirror_clk_en;
  endproperty
  a_ext: assert property (p_ext) else $error("external reset released early"); // see R13

  property p_gpio;
    @(posedge ref_clk) disable iff (!nrst)
    gpio_oe == '0;
  endproperty
  a_gpio: assert property (p_gpio) else $error("gpio driven"); // see R3

  // Busy must show within a bounded time of every system reset release.
  sequence s_busy_start;
    $fell(sys_rst) ##0 !ctrl[rbs_pkg::CB_INIT_DONE];
  endsequence
  property p_busy_rise;
    @(posedge ref_clk) disable iff (!nrst)
    s_busy_start |-> ##[1:30] init_status;
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("init status did not rise"); // see R15

  // Processor reset leaves only after two clean edges of released system reset.
  property p_cpu_sync;
    @(posedge ref_clk) disable iff (!nrst)
    $rose(cpu_rst_n) |-> $past(sys_rst_n) && $past(sys_rst_n, 2);
  endproperty
  a_cpu_sync: assert property (p_cpu_sync) else $error("processor reset released early"); // see R18

endmodule : rbs_sequencer

`default_nettype wire

// ### sim/rbs_host_model.sv
// Host model that polls the init status pin before it touches the device.
// Assumes nrst is the power-up reset and init_status is combinational from registers on ref_clk.
`timescale 1ns/10ps
`default_nettype none
module rbs_host_model (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       init_status,
  output logic            host_ready,
  output logic      [7:0] pulse_len
);
  logic       busy_seen;
  logic [7:0] run;
  // A pulse seen before the busy phase ends is busy, not an error.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      busy_seen  <= 1'b0;
      host_ready <= 1'b0;
      run        <= 8'h00;
      pulse_len  <= 8'h00;
    end else begin
      if (init_status && !host_ready) busy_seen <= 1'b1;
      if (busy_seen && !init_status) host_ready <= 1'b1;
      if (host_ready && init_status) run <= run + 8'h01;
      else if (run != 8'h00) begin
        pulse_len <= run;
        run       <= 8'h00;
      end
    end
  end
endmodule : rbs_host_model
`default_nettype wire

// ### sim/test_reset_boot_sequencer.sv
// Self-checking bench for the reset and boot sequencer.
// Assumes the Wishbone slave answers one cycle after it takes a request.
`timescale 1ns/10ps
`default_nettype none
module test_reset_boot_sequencer;
  logic        ref_clk = 1'b0, nrst = 1'b0, supply_good_input = 1'b1;
  logic        wdog_expired = 1'b0, wake_request = 1'b0, mirror_interface_pll_lock = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, a;
  logic [7:0]  wb_adr_i = 8'h00, pulse_len;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic        wb_ack_o, master_pll_rst, normal_power, cpu_rst_n, cpu_clk_full, boot_from_flash;
  logic        core_rst_n, fe_clk_en, mirror_interface_pll_en, ddr_clock_generator_div_rst_n;
  logic        mirror_clk_en, ext_rst_n, mirror_driver_output_enable_n, mirror_driver_output_enable_n_oe;
  logic        init_status, irq, host_ready;
  logic [37:0] gpio_oe;
  logic [15:0] mirror_data_o, mirror_data_oe;
  int          fail_count = 0, n_tests = 0;
  always #12.5 ref_clk = ~ref_clk;
  rbs_sequencer dut (.ref_clk, .nrst, .supply_good_input, .wdog_expired, .wake_request,
    .mirror_interface_pll_lock, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .master_pll_rst, .normal_power, .cpu_rst_n, .cpu_clk_full,
    .boot_from_flash, .core_rst_n, .fe_clk_en, .mirror_interface_pll_en, .ddr_clock_generator_div_rst_n,
    .mirror_clk_en, .ext_rst_n, .gpio_oe, .mirror_data_o, .mirror_data_oe, .mirror_driver_output_enable_n,
    .mirror_driver_output_enable_n_oe, .init_status, .irq);
  rbs_host_model host (.ref_clk, .nrst, .init_status, .host_ready, .pulse_len);
  task automatic print_verdict;
    if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      fail_count++;
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  // Leading edge keeps cyc low for a cycle between two transfers.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
  endtask : wb
  task automatic wait_st(input logic v, input int lim);
    int n;
    n = 0;
    while (init_status !== v && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    chk(init_status, v);
  endtask : wait_st
  task automatic t_defaults;
    chk({master_pll_rst, normal_power, cpu_clk_full, boot_from_flash, cpu_rst_n}, 5'h0F);
    chk({core_rst_n, fe_clk_en, mirror_interface_pll_en, ddr_clock_generator_div_rst_n}, 4'h0);
    chk({mirror_clk_en, ext_rst_n}, 2'h0);
    chk({gpio_oe, mirror_data_o, mirror_driver_output_enable_n_oe}, 55'h0);
    chk(mirror_data_oe, 16'hFFFF);
    chk(mirror_driver_output_enable_n, 1'b1);
  endtask : t_defaults
  // Unmapped place and a write without byte lane zero both leave control alone.
  task automatic t_regs;
    wb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0);
    wb_sel_i <= 4'h0;
    wb(1'b1, rbs_pkg::OFS_CTRL, 32'h2);
    wb_sel_i <= 4'hF;
    wb(1'b1, 8'h14, 32'hFFFFFFFF);
    wb(1'b0, rbs_pkg::OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    chk(fe_clk_en, 1'b0);
    wb(1'b1, rbs_pkg::OFS_ERR, 32'h5A);
    wb(1'b0, rbs_pkg::OFS_ERR, 32'h0);
    chk(rd, 32'h5A);
    wb(1'b1, rbs_pkg::OFS_CTRL, 32'h200);
    cyc(1);
    chk({mirror_driver_output_enable_n, mirror_driver_output_enable_n_oe}, 2'h1);
    wb(1'b1, rbs_pkg::OFS_CTRL, 32'h0);
  endtask : t_regs
  task automatic t_boot;
    wb(1'b1, rbs_pkg::OFS_CTRL, 32'h4);
    cyc(2);
    chk({mirror_interface_pll_en, ddr_clock_generator_div_rst_n, mirror_clk_en}, 3'h4);
    wb(1'b1, rbs_pkg::OFS_CTRL, 32'h1F);
    cyc(2);
    chk({core_rst_n, fe_clk_en, ddr_clock_generator_div_rst_n, ext_rst_n}, 4'hC);
    mirror_interface_pll_lock <= 1'b1;
    cyc(4);
    wb(1'b1, rbs_pkg::OFS_CTRL, 32'h1F);
    cyc(2);
    chk({ddr_clock_generator_div_rst_n, mirror_clk_en, ext_rst_n}, 3'h7);
  endtask : t_boot
  task automatic t_irq;
    wb(1'b1, rbs_pkg::OFS_MASK, 32'hF);
    cyc(2);
    a = irq;
    wb(1'b1, rbs_pkg::OFS_MASK, 32'h0);
    cyc(2);
    chk(a ^ irq, 1'b1);
    wb(1'b0, rbs_pkg::OFS_IRQ, 32'h0);
    chk(rd[0], 1'b1);
    wb(1'b1, rbs_pkg::OFS_IRQ, 32'h1);
    wb(1'b0, rbs_pkg::OFS_IRQ, 32'h0);
    chk(rd[0], 1'b0);
    cyc(2);
    chk(irq, 1'b0);
  endtask : t_irq
  task automatic t_wake;
    wb(1'b1, rbs_pkg::OFS_CTRL, 32'hDF);
    cyc(2);
    chk({normal_power, cpu_clk_full}, 2'h0);
    wake_request <= 1'b1;
    cyc(4);
    wake_request <= 1'b0;
    chk({normal_power, cpu_clk_full}, 2'h3);
    wb(1'b0, rbs_pkg::OFS_IRQ, 32'h0);
    chk(rd[1], 1'b1);
    wb(1'b1, rbs_pkg::OFS_CTRL, 32'h1F);
    cyc(2);
    chk(normal_power, 1'b1);
  endtask : t_wake
  task automatic t_err;
    wb(1'b1, rbs_pkg::OFS_CTRL, 32'h3F);
    wait_st(1'b0, 50);
    cyc(2);
    chk(host_ready, 1'b1);
    wb(1'b0, rbs_pkg::OFS_STATUS, 32'h0);
    chk(rd[1], 1'b0);
    wb(1'b1, rbs_pkg::OFS_CTRL, 32'h13F);
    cyc(60);
    chk(pulse_len, rbs_pkg::ERR_PULSE_CYC);
  endtask : t_err
  task automatic t_sys(input logic sup);
    wb(1'b1, rbs_pkg::OFS_CTRL, 32'h3F);
    wait_st(1'b0, 50);
    if (sup) supply_good_input <= 1'b0;
    else wdog_expired <= 1'b1;
    cyc(6);
    chk({master_pll_rst, ext_rst_n, core_rst_n, cpu_rst_n}, 4'h0);
    supply_good_input <= 1'b1;
    wdog_expired      <= 1'b0;
    wait_st(1'b1, 80);
    t_defaults();
    wb(1'b0, rbs_pkg::OFS_STATUS, 32'h0);
    chk(rd[4:3], sup ? rbs_pkg::CAUSE_SUPPLY : rbs_pkg::CAUSE_WDOG);
    wb(1'b0, rbs_pkg::OFS_IRQ, 32'h0);
    chk(rd[sup ? 2 : 3], 1'b1);
  endtask : t_sys
  initial begin
    cyc(2);
    chk(master_pll_rst, 1'b1);
    cyc(2);
    nrst <= 1'b1;
    cyc(1);
    chk(cpu_rst_n, 1'b0);
    wait_st(1'b1, 60);
    t_defaults();
    t_regs();
    t_boot();
    t_irq();
    t_wake();
    t_err();
    t_sys(1'b0);
    t_sys(1'b1);
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    print_verdict();
  end
endmodule : test_reset_boot_sequencer
`default_nettype wire
